// *** dbs_sram_port.sv ***
`timescale 1ns/10ps
module dbs_sram_port
  import dbs_pkg::*;
#(
  parameter int ADDR_W = PKG_ADDR_W,
  parameter int LANE_W = PKG_LANE_W,
  parameter int FIFO_DEPTH = PKG_FIFO_DEPTH
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic read_sel_n,
  input wire logic write_sel_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic lane0_write_enable_n,
  input wire logic lane1_write_enable_n,
  input wire logic [LANE_W*PKG_LANES-1:0] wdata,
  output logic [LANE_W*PKG_LANES-1:0] rdata,
  output logic rdata_oe
);
  localparam int DATA_W = LANE_W * PKG_LANES;
  localparam int IN_W = 3 + PKG_LANES + ADDR_W + DATA_W;
  localparam int WB_W = ADDR_W + PKG_LANES + DATA_W;

  // ==========================================================
  // parameter check
  if (ADDR_W < 2 || ADDR_W > 24 || LANE_W < 1 || FIFO_DEPTH < 2)
  begin : g_bad_param
    $error("unsupported address width, lane width or buffer depth");
  end

  // ==========================================================
  // beat lookup: hit flag and beat number within a pipe window
  function automatic logic [BEAT_W:0] find_beat(input logic [PIPE_DEPTH-1:0] v,
                                                input int first);
    logic [BEAT_W:0] r;
    r = '0;
    for (int k = 0; k < BURST; k++)
      if (v[first+k])
        r = {1'b1, BEAT_W'(k)};
    return r;
  endfunction : find_beat

  // ==========================================================
  // pin synchronisers, all pins share the same delay
  logic [IN_W-1:0] pin_now, sync1, sync2;
  logic k_prev, next_k_prev;
  logic k_s, r_n_s, w_n_s;
  logic [PKG_LANES-1:0] be_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] wdata_s;
  logic rise, fall, half;

  assign pin_now = {link_clk, read_sel_n, write_sel_n, lane1_write_enable_n,
                    lane0_write_enable_n, addr, wdata};
  assign {k_s, r_n_s, w_n_s, be_n_s, addr_s, wdata_s} = sync2;

  always_ff @(posedge core_clk)
  begin
    sync1 <= pin_now;
    sync2 <= sync1;
  end

  assign next_k_prev = k_s;
  assign rise = k_s & ~k_prev;
  assign fall = ~k_s & k_prev;
  assign half = rise | fall;

  // ==========================================================
  // command acceptance and half-edge pipes
  logic rd_acc, wr_acc;
  logic prev_rd, next_prev_rd, prev_wr, next_prev_wr, prev_nop, next_prev_nop;
  logic [PIPE_DEPTH-1:0] rd_v, next_rd_v, wr_v, next_wr_v;
  logic [ADDR_W-1:0] rd_a [PIPE_DEPTH];
  logic [ADDR_W-1:0] next_rd_a [PIPE_DEPTH];
  logic [ADDR_W-1:0] wr_a [PIPE_DEPTH];
  logic [ADDR_W-1:0] next_wr_a [PIPE_DEPTH];

  // commands only on a rise; a rise right after an accepted one of its kind is dropped
  assign rd_acc = rise & ~r_n_s & ~prev_rd;
  assign wr_acc = rise & ~w_n_s & ~prev_wr & ~(~r_n_s & prev_nop);

  always_comb
  begin
    next_rd_v = rd_v;
    next_rd_a = rd_a;
    next_wr_v = wr_v;
    next_wr_a = wr_a;
    next_prev_rd = prev_rd;
    next_prev_wr = prev_wr;
    next_prev_nop = prev_nop;
    // pipes step on every half edge, so a stopped clock freezes them
    if (half)
    begin
      for (int i = PIPE_DEPTH - 1; i > 0; i--)
      begin
        next_rd_v[i] = rd_v[i-1];
        next_rd_a[i] = rd_a[i-1];
        next_wr_v[i] = wr_v[i-1];
        next_wr_a[i] = wr_a[i-1];
      end
      // separate read and write lanes, both may be busy at once
      next_rd_v[0] = rd_acc;
      next_rd_a[0] = addr_s;
      next_wr_v[0] = wr_acc;
      next_wr_a[0] = addr_s;
    end
    if (rise)
    begin
      next_prev_rd = rd_acc;
      next_prev_wr = wr_acc;
      next_prev_nop = r_n_s & w_n_s;
    end
  end

  // ==========================================================
  // beat addresses
  logic [BEAT_W:0] rd_find, wr_find;
  logic [ADDR_W-1:0] rd_beat_a, wr_beat_a;

  assign rd_find = find_beat(next_rd_v, RD_FIRST_HALF);
  assign wr_find = find_beat(next_wr_v, WR_FIRST_HALF);
  assign rd_beat_a = next_rd_a[RD_FIRST_HALF + int'(rd_find[BEAT_W-1:0])]
                     + ADDR_W'(rd_find[BEAT_W-1:0]);
  assign wr_beat_a = next_wr_a[WR_FIRST_HALF + int'(wr_find[BEAT_W-1:0])]
                     + ADDR_W'(wr_find[BEAT_W-1:0]);

  // ==========================================================
  // write buffer and array
  dbs_fifo_if #(.WIDTH(WB_W)) wbuf ();
  logic wb_v, next_wb_v;
  logic [WB_W-1:0] wb_d, next_wb_d;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [ADDR_W-1:0] m_a;
  logic [PKG_LANES-1:0] m_be_n;
  logic rd_due, next_rd_due, rd_fire;
  logic [ADDR_W-1:0] rd_due_a, next_rd_due_a;
  logic [DATA_W-1:0] next_rdata;
  logic next_oe;

  dbs_fifo #(.WIDTH(WB_W), .DEPTH(FIFO_DEPTH)) u_wbuf (
    .core_clk(core_clk),
    .resetn(resetn),
    .f(wbuf)
  );

  assign wbuf.s_valid = wb_v;
  assign wbuf.s_data = wb_d;
  // the array port drains buffered writes first; the read fires only once the buffer is empty
  // a beat still in the holding stage must land too, or the read sees stale data
  assign rd_fire = rd_due & ~wbuf.m_valid & ~wb_v;
  assign wbuf.m_ready = ~rd_fire;
  assign {m_a, m_be_n} = wbuf.m_data[WB_W-1 -: ADDR_W + PKG_LANES];

  always_ff @(posedge core_clk)
  begin
    if (wbuf.m_valid && wbuf.m_ready)
      for (int l = 0; l < PKG_LANES; l++)
        if (!m_be_n[l])
          mem[m_a][l*LANE_W +: LANE_W] <= wbuf.m_data[l*LANE_W +: LANE_W];
  end

  // ==========================================================
  // read output and write capture
  always_comb
  begin
    next_rd_due = rd_due;
    next_rd_due_a = rd_due_a;
    next_rdata = rdata;
    next_oe = rdata_oe;
    next_wb_v = wb_v & ~wbuf.s_ready;
    next_wb_d = wb_d;
    // a read waits until older buffered writes reach the array
    if (rd_fire)
    begin
      next_rdata = mem[rd_due_a];
      next_oe = 1'b1;
      next_rd_due = 1'b0;
    end
    if (half)
    begin
      if (rd_find[BEAT_W])
      begin
        next_rd_due = 1'b1;
        next_rd_due_a = rd_beat_a;
      end
      else
        next_oe = 1'b0;
      // a full holding stage loses the beat; at link rates it never fills
      if (wr_find[BEAT_W] && !(&be_n_s) && !next_wb_v)
      begin
        next_wb_v = 1'b1;
        next_wb_d = {wr_beat_a, be_n_s, wdata_s};
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      // follow the pin through reset, so release shows no false edge
      k_prev <= next_k_prev;
      prev_rd <= 1'b0;
      prev_wr <= 1'b0;
      prev_nop <= PREV_NOP_RESET;
      rd_v <= '0;
      wr_v <= '0;
      rd_due <= 1'b0;
      rd_due_a <= '0;
      wb_v <= 1'b0;
      wb_d <= '0;
      rdata <= '0;
      rdata_oe <= 1'b0;
    end
    else
    begin
      k_prev <= next_k_prev;
      prev_rd <= next_prev_rd;
      prev_wr <= next_prev_wr;
      prev_nop <= next_prev_nop;
      rd_v <= next_rd_v;
      wr_v <= next_wr_v;
      rd_due <= next_rd_due;
      rd_due_a <= next_rd_due_a;
      wb_v <= next_wb_v;
      wb_d <= next_wb_d;
      rdata <= next_rdata;
      rdata_oe <= next_oe;
    end
  end

  // addresses are qualified by their valid bits
  always_ff @(posedge core_clk)
  begin
    rd_a <= next_rd_a;
    wr_a <= next_wr_a;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_rise_read;
    rise && !r_n_s;
  endsequence

  sequence s_fresh_read;
    s_rise_read ##0 !prev_rd;
  endsequence

  property p_read_start;
    s_fresh_read |-> rd_acc ##1 rd_v[0];
  endproperty
  a_read_start: assert property (p_read_start) else $error("read not started");

  property p_write_start;
    rise && !w_n_s && !prev_wr && !(!r_n_s && prev_nop) |=> wr_v[0];
  endproperty
  a_write_start: assert property (p_write_start) else $error("write not started");

  property p_back_to_back;
    rise && prev_rd |-> !rd_acc;
  endproperty
  a_back_to_back: assert property (p_back_to_back) else $error("second read kept");

  property p_read_wins;
    rise && prev_nop && !r_n_s && !w_n_s |-> rd_acc && !wr_acc;
  endproperty
  a_read_wins: assert property (p_read_wins) else $error("write kept over read");

  property p_only_rise;
    !rise |-> !rd_acc && !wr_acc;
  endproperty
  a_only_rise: assert property (p_only_rise) else $error("command off a rise");

  // later beats step one address on from the beat before
  property p_beat_addr;
    half && rd_find[BEAT_W] && rd_find[BEAT_W-1:0] != '0
      |=> rd_due_a == $past(rd_due_a) + ADDR_W'(1);
  endproperty
  a_beat_addr: assert property (p_beat_addr) else $error("beat address wrong");

  property p_idle_hiz;
    half && !rd_find[BEAT_W] && !rd_fire |=> !rdata_oe;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz) else $error("read pins driven on idle");

  property p_hold_stopped;
    !half && !rd_fire |=> $stable(rdata) && $stable(rdata_oe) && $stable(rd_v);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped) else $error("state moved");

  property p_read_after_drain;
    rd_fire |-> !wbuf.m_valid && !wb_v ##1 rdata_oe;
  endproperty
  a_read_after_drain: assert property (p_read_after_drain) else $error("read passed buffer");

  property p_no_abort_push;
    wbuf.s_valid |-> !(&wbuf.s_data[DATA_W +: PKG_LANES]);
  endproperty
  a_no_abort_push: assert property (p_no_abort_push) else $error("aborted beat stored");

  property p_read_latency;
    rd_v[RD_FIRST_HALF-1] && half |=> rd_due [*1] ##[0:12] rdata_oe;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read beat late");
endmodule : dbs_sram_port

// *** dbs_pkg.sv ***
package dbs_pkg;
  // ==========================================================
  // widths
  localparam int PKG_LANES = 2;
  localparam int PKG_LANE_W = 9;
  localparam int PKG_ADDR_W = 19;
  localparam int BURST = 4;
  localparam int BEAT_W = 2;
  // ==========================================================
  // timing, in link clock half edges after the command rise
  localparam int RD_FIRST_HALF = 5;
  localparam int WR_FIRST_HALF = 2;
  localparam int PIPE_DEPTH = RD_FIRST_HALF + BURST;
  // ==========================================================
  // buffering and reset values
  localparam int PKG_FIFO_DEPTH = 8;
  localparam logic PREV_NOP_RESET = 1'b1;
endpackage : dbs_pkg

// *** dbs_fifo_if.sv ***
`timescale 1ns/10ps
interface dbs_fifo_if #(
  parameter int WIDTH = 8
);
  logic s_valid;
  logic s_ready;
  logic [WIDTH-1:0] s_data;
  logic m_valid;
  logic m_ready;
  logic [WIDTH-1:0] m_data;
  modport buffer (input s_valid, input s_data, input m_ready,
                  output s_ready, output m_valid, output m_data);
  modport user (output s_valid, output s_data, output m_ready,
                input s_ready, input m_valid, input m_data);
endinterface : dbs_fifo_if

// *** dbs_fifo.sv ***
`timescale 1ns/10ps
module dbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  input wire logic core_clk,
  input wire logic resetn,
  dbs_fifo_if.buffer f
);
  localparam int PTR_W = $clog2(DEPTH);

  // ==========================================================
  // parameter check
  if (DEPTH < 2 || (1 << PTR_W) != DEPTH)
  begin : g_bad_depth
    $error("fifo depth must be a power of two, at least two");
  end

  // ==========================================================
  // storage and pointers
  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W:0] wp, next_wp, rp, next_rp;
  logic full, empty, push, pop;

  assign empty = (wp == rp);
  assign full = (wp[PTR_W] != rp[PTR_W]) && (wp[PTR_W-1:0] == rp[PTR_W-1:0]);
  assign f.s_ready = ~full;
  assign f.m_valid = ~empty;
  assign f.m_data = store[rp[PTR_W-1:0]];
  assign push = f.s_valid & ~full;
  assign pop = f.m_ready & ~empty;

  always_comb
  begin
    next_wp = wp + (PTR_W+1)'(push);
    next_rp = rp + (PTR_W+1)'(pop);
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      wp <= '0;
      rp <= '0;
    end
    else
    begin
      wp <= next_wp;
      rp <= next_rp;
    end
  end

  // data words carry no control meaning, so no reset
  always_ff @(posedge core_clk)
  begin
    if (push)
      store[wp[PTR_W-1:0]] <= f.s_data;
  end
endmodule : dbs_fifo

// *** dbs_ctrl_model.sv ***
`timescale 1ns/10ps
// ==========================================================
// far-side controller model
module dbs_ctrl_model
  import dbs_pkg::*;
#(
  parameter int AW = 6
)
(
  input wire logic core_clk,
  output logic link_clk,
  output logic read_sel_n,
  output logic write_sel_n,
  output logic [AW-1:0] addr,
  output logic lane0_write_enable_n,
  output logic lane1_write_enable_n,
  output logic [PKG_LANE_W*PKG_LANES-1:0] wdata
);
  initial
  begin
    link_clk = 1'b0;
    read_sel_n = 1'b1;
    write_sel_n = 1'b1;
    addr = '0;
    lane0_write_enable_n = 1'b1;
    lane1_write_enable_n = 1'b1;
    wdata = '0;
  end
  // one half link period: 20 core cycles, so 160 ns per link cycle
  // clock moves only inside half(), caller stops after bursts drain
  task automatic half(input logic rd_n, input logic wr_n, input logic [AW-1:0] a,
    input logic [1:0] en_n, input logic [PKG_LANE_W*PKG_LANES-1:0] d, input logic live);
    @(posedge core_clk);
    read_sel_n <= rd_n;
    write_sel_n <= wr_n;
    addr <= a;
    lane0_write_enable_n <= en_n[0];
    lane1_write_enable_n <= en_n[1];
    // released data lines toggle so stale values never look valid
    wdata <= live ? d : ~wdata;
    repeat (9) @(posedge core_clk);
    link_clk <= ~link_clk;
    repeat (10) @(posedge core_clk);
  endtask : half
endmodule : dbs_ctrl_model

// *** test_ddr_burst4_sram_port.sv ***
`timescale 1ns/10ps
module test_ddr_burst4_sram_port
  import dbs_pkg::*;
;
  localparam int AW = 6;
  localparam int DW = PKG_LANE_W * PKG_LANES;
  localparam int NR = 16;
  localparam int NH = 2 * NR;
  typedef struct packed {logic rd_n; logic wr_n; logic [AW-1:0] a; logic msk;
    logic rd_ok; logic wr_ok;} dbs_row_t;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic link_clk;
  logic read_sel_n;
  logic write_sel_n;
  logic [AW-1:0] addr;
  logic en0_n;
  logic en1_n;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  logic rdata_oe;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] last;
  logic rd_v [0:NH+9];
  logic wr_v [0:NH+9];
  logic [AW-1:0] rd_a [0:NH+9];
  logic [AW-1:0] wr_a [0:NH+9];
  logic [1:0] wr_en [0:NH+9];
  logic [DW-1:0] wr_d [0:NH+9];
  int h;
  // ==========================================================
  // command rows, one per link rise, with whether read and write are taken
  // rows 11 and 12 land a write beat on the word a read beat fetches in that half
  dbs_row_t rows [NR] = '{
    '{1'b1, 1'b1, 6'h00, 1'b0, 1'b0, 1'b0}, '{1'b1, 1'b0, 6'h10, 1'b0, 1'b0, 1'b1},
    '{1'b1, 1'b1, 6'h00, 1'b0, 1'b0, 1'b0}, '{1'b1, 1'b0, 6'h20, 1'b0, 1'b0, 1'b1},
    '{1'b1, 1'b0, 6'h30, 1'b0, 1'b0, 1'b0}, '{1'b0, 1'b0, 6'h20, 1'b1, 1'b1, 1'b1},
    '{1'b1, 1'b1, 6'h00, 1'b0, 1'b0, 1'b0}, '{1'b0, 1'b0, 6'h10, 1'b1, 1'b1, 1'b0},
    '{1'b0, 1'b1, 6'h30, 1'b0, 1'b0, 1'b0}, '{1'b0, 1'b1, 6'h20, 1'b0, 1'b1, 1'b0},
    '{1'b1, 1'b1, 6'h00, 1'b0, 1'b0, 1'b0}, '{1'b0, 1'b1, 6'h10, 1'b0, 1'b1, 1'b0},
    '{1'b1, 1'b0, 6'h0F, 1'b1, 1'b0, 1'b1}, '{1'b1, 1'b1, 6'h00, 1'b0, 1'b0, 1'b0},
    '{1'b1, 1'b1, 6'h00, 1'b0, 1'b0, 1'b0}, '{1'b1, 1'b1, 6'h00, 1'b0, 1'b0, 1'b0}};
  always #2 core_clk = ~core_clk;
  dbs_sram_port #(.ADDR_W(AW)) DUT (.core_clk(core_clk), .resetn(resetn), .link_clk(link_clk),
    .read_sel_n(read_sel_n), .write_sel_n(write_sel_n), .addr(addr),
    .lane0_write_enable_n(en0_n), .lane1_write_enable_n(en1_n), .wdata(wdata),
    .rdata(rdata), .rdata_oe(rdata_oe));
  dbs_ctrl_model #(.AW(AW)) ctrl (.core_clk(core_clk), .link_clk(link_clk),
    .read_sel_n(read_sel_n), .write_sel_n(write_sel_n), .addr(addr),
    .lane0_write_enable_n(en0_n), .lane1_write_enable_n(en1_n), .wdata(wdata));
  // ==========================================================
  // checking and closing
  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // run is about 1000 cycles; ceiling leaves wide margin
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  // ==========================================================
  // main sequence
  initial
  begin
    for (int i = 0; i < NH + 10; i++)
    begin
      rd_v[i] = 1'b0;
      wr_v[i] = 1'b0;
    end
    // only taken commands mark beats, so a dropped one cannot clear a neighbour's
    for (int r = 0; r < NR; r++)
    begin
      for (int k = 0; k < BURST; k++)
      begin
        if (rows[r].rd_ok)
        begin
          rd_v[2*r+5+k] = 1'b1;
          rd_a[2*r+5+k] = rows[r].a + AW'(k);
        end
        if (rows[r].wr_ok)
        begin
          wr_v[2*r+2+k] = 1'b1;
          wr_a[2*r+2+k] = rows[r].a + AW'(k);
          // masked bursts walk lane0, lane1, both, none (abort)
          wr_en[2*r+2+k] = rows[r].msk ? 2'(8'h93 >> (2 * (3 - k))) : 2'b00;
          wr_d[2*r+2+k] = {3'h5, wr_a[2*r+2+k], 3'h2, wr_a[2*r+2+k]} ^ {DW{rows[r].msk}};
        end
      end
    end
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    for (h = 0; h < NH; h++)
    begin
      // selects are driven low at falls: only rises may start bursts
      ctrl.half(h % 2 ? 1'b0 : rows[h/2].rd_n, h % 2 ? 1'b0 : rows[h/2].wr_n,
        h % 2 ? ~rows[h/2].a : rows[h/2].a, wr_v[h] ? wr_en[h] : 2'b11, wr_d[h], wr_v[h]);
      if (wr_v[h] && !wr_en[h][0])
        mem[wr_a[h]][PKG_LANE_W-1:0] = wr_d[h][PKG_LANE_W-1:0];
      if (wr_v[h] && !wr_en[h][1])
        mem[wr_a[h]][DW-1:PKG_LANE_W] = wr_d[h][DW-1:PKG_LANE_W];
      #1;
      check(DW'(rdata_oe), DW'(rd_v[h]));
      if (rd_v[h])
      begin
        last = mem[rd_a[h]];
        check(rdata, last);
      end
    end
    // ==========================================================
    // link clock stopped, then a second reset
    repeat (100) @(posedge core_clk);
    #1;
    check(rdata, last);
    check(DW'(rdata_oe), '0);
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (10) @(posedge core_clk);
    #1;
    check(rdata, '0);
    check(DW'(rdata_oe), '0);
    // ==========================================================
    // after release the array keeps its words and a first read works
    @(posedge core_clk);
    resetn <= 1'b1;
    for (h = 0; h < 10; h++)
    begin
      ctrl.half(h == 0 ? 1'b0 : 1'b1, 1'b1, 6'h20, 2'b11, '0, 1'b0);
      #1;
      check(DW'(rdata_oe), DW'(h >= 5 && h <= 8));
      if (h >= 5 && h <= 8)
        check(rdata, mem[6'h20 + AW'(h - 5)]);
    end
    report_and_stop();
  end
endmodule : test_ddr_burst4_sram_port
